// >>> verilog/frame_byte_counter_limit.sv
// Frame byte tally with programmable 12-bit threshold and masked event output.
// Assumes byte strobes from the transmit and receive paths, one cycle each,
// and a byte-wide register port with read data one cycle after the strobe.
//
// Contract
// - One 12-bit tally shared by TX and RX, read as low byte and high nibble.
// - TX counts each byte sent after the delimiter; CRC bytes never counted.
// - RX counts each byte written to receive FIFO, including PHY header and CRC; the code skips FIFO bytes flagged rxPreambleByte.
// - After reset the tally low byte and high nibble read zero.
// - High tally bits 7 to 4 reserved; write zero, reads undefined.
// - Writable 8-bit low threshold, reset zero, compared against active direction.
// - TX tally reaching threshold raises event when TX event unmasked.
// - RX tally reaching threshold raises event when RX event unmasked.
// - Reaching threshold never affects state machines or FIFO, only the event.
// - Upper four threshold bits in bits 3-0 of separate register, reset zero.
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module frame_byte_counter_limit (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  // Register port
  input  wire logic [tally_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [7:0]                  regWrData,
  input  wire logic                        regWrite,
  input  wire logic                        regRead,
  output logic      [7:0]                  regRdData,
  // Transmit path
  input  wire logic                        txFrameStart,
  input  wire logic                        txByteSent,
  input  wire logic                        txAfterDelim,
  input  wire logic                        txCrcByte,
  // Receive path
  input  wire logic                        rxFrameStart,
  input  wire logic                        rxFifoWrite,
  input  wire logic                        rxPreambleByte,
  // Events to the embedded controller
  output logic                             tx_threshold_event,
  output logic                             rx_threshold_event
);
  // Tally and threshold
  logic [tally_pkg::TALLY_W-1:0] running_byte_tally;
  logic [tally_pkg::TALLY_W-1:0] next_running_byte_tally;
  logic [tally_pkg::TALLY_W-1:0] tally_threshold;
  logic [tally_pkg::TALLY_W-1:0] next_tally_threshold;

  // Mask, sticky status and event pulses; bit 0 TX, bit 1 RX
  logic [1:0]                    eventMask;
  logic [1:0]                    next_eventMask;
  logic [1:0]                    eventStat;
  logic [1:0]                    next_eventStat;
  logic [1:0]                    eventPulse;
  logic [1:0]                    next_eventPulse;
  logic [1:0]                    dirHit;

  // Register port
  logic [7:0]                    next_regRdData;
  logic                          wrLimitLow;
  logic                          wrLimitHigh;
  logic                          wrMask;
  logic                          wrStat;

  // Direction and byte qualification
  tally_pkg::dir_t               dir;
  tally_pkg::dir_t               next_dir;
  logic                          txQualByte;
  logic                          rxQualByte;
  logic                          countByte;
  logic                          frameStart;
  logic                          hit;

  assign frameStart = txFrameStart || rxFrameStart;

  // Direction follows the most recent frame start; TX wins if both start at once
  always_comb begin
    next_dir = dir;
    case (dir)
      tally_pkg::DIR_IDLE: begin
        if (txFrameStart) begin
          next_dir = tally_pkg::DIR_TX;
        end else if (rxFrameStart) begin
          next_dir = tally_pkg::DIR_RX;
        end
      end

      tally_pkg::DIR_TX: begin
        // A receive start hands the shared tally over to RX
        if (rxFrameStart && !txFrameStart) begin
          next_dir = tally_pkg::DIR_RX;
        end
      end

      tally_pkg::DIR_RX: begin
        if (txFrameStart) begin
          next_dir = tally_pkg::DIR_TX;
        end
      end

      default: begin
        next_dir = tally_pkg::DIR_IDLE;
      end
    endcase
  end

  // Byte qualification per direction
  assign txQualByte = txByteSent && txAfterDelim && !txCrcByte;
  assign rxQualByte = rxFifoWrite && !rxPreambleByte;

  // Only the latched direction counts; the other path's strobes are ignored
  always_comb begin
    countByte = 1'b0;
    case (dir)
      tally_pkg::DIR_TX: begin
        countByte = txQualByte;
      end

      tally_pkg::DIR_RX: begin
        countByte = rxQualByte;
      end

      default: begin
        countByte = 1'b0;
      end
    endcase
  end

  // Tally: cleared at frame start, software writes ignored to keep it sane
  always_comb begin
    next_running_byte_tally = running_byte_tally;
    if (frameStart) begin
      next_running_byte_tally = tally_pkg::TALLY_RST;
    end else if (countByte) begin
      next_running_byte_tally = running_byte_tally + 12'h001;
    end
  end

  // Write decode; tally indices decode to nothing, so stray writes fall away
  assign wrLimitLow  = regWrite
                       && (regAddr == tally_pkg::LIMIT_LOW_ADDR);
  assign wrLimitHigh = regWrite
                       && (regAddr == tally_pkg::LIMIT_HIGH_ADDR);
  assign wrMask      = regWrite
                       && (regAddr == tally_pkg::EVENT_MASK_ADDR);
  assign wrStat      = regWrite
                       && (regAddr == tally_pkg::EVENT_STAT_ADDR);

  // Threshold; the high write keeps only the nibble, reserved bits dropped
  always_comb begin
    next_tally_threshold = tally_threshold;
    if (wrLimitLow) begin
      next_tally_threshold[7:0] = regWrData;
    end
    if (wrLimitHigh) begin
      next_tally_threshold[11:8] = regWrData[3:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tally_threshold <= tally_pkg::LIMIT_RST;
    end else begin
      tally_threshold <= next_tally_threshold;
    end
  end

  // Mask: 1 holds the event back, status still records the hit
  always_comb begin
    next_eventMask = eventMask;
    if (wrMask) begin
      next_eventMask = regWrData[1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      eventMask <= tally_pkg::MASK_RST;
    end else begin
      eventMask <= next_eventMask;
    end
  end

  // Hit split by the direction that owns the tally
  assign dirHit[tally_pkg::TX_EVT_BIT] = hit
                                         && (dir == tally_pkg::DIR_TX);
  assign dirHit[tally_pkg::RX_EVT_BIT] = hit
                                         && (dir == tally_pkg::DIR_RX);

  // Events are pulses; they feed nothing back into the datapath
  for (genvar g = 0; g < 2; g++) begin : g_dir
    always_comb begin
      next_eventPulse[g] = dirHit[g] && !eventMask[g];
      next_eventStat[g]  = eventStat[g];
      if (wrStat && regWrData[g]) begin
        next_eventStat[g] = 1'b0;
      end
      // Set wins over a simultaneous clear, so no hit is lost
      if (dirHit[g]) begin
        next_eventStat[g] = 1'b1;
      end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        eventPulse[g] <= 1'b0;
        eventStat[g]  <= 1'b0;
      end else begin
        eventPulse[g] <= next_eventPulse[g];
        eventStat[g]  <= next_eventStat[g];
      end
    end
  end

  assign tx_threshold_event = eventPulse[tally_pkg::TX_EVT_BIT];
  assign rx_threshold_event = eventPulse[tally_pkg::RX_EVT_BIT];

  // Read mux; reserved bits return zero
  always_comb begin
    next_regRdData = tally_pkg::UNMAPPED_RD;
    if (regRead) begin
      case (regAddr)
        tally_pkg::COUNT_LOW_ADDR: begin
          next_regRdData = running_byte_tally[7:0];
        end

        // Reserved high bits always read zero
        tally_pkg::COUNT_HIGH_ADDR: begin
          next_regRdData = {4'h0, running_byte_tally[11:8]};
        end

        tally_pkg::LIMIT_LOW_ADDR: begin
          next_regRdData = tally_threshold[7:0];
        end
        tally_pkg::LIMIT_HIGH_ADDR: begin
          next_regRdData = {4'h0, tally_threshold[11:8]};
        end

        tally_pkg::EVENT_MASK_ADDR: begin
          next_regRdData = {6'h00, eventMask};
        end

        tally_pkg::EVENT_STAT_ADDR: begin
          next_regRdData = {6'h00, eventStat};
        end
        default: begin
          next_regRdData = tally_pkg::UNMAPPED_RD;
        end
      endcase
    end
  end

  limit_compare u_limit_compare (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .tally      (running_byte_tally),
    .limit      (tally_threshold),
    .frameStart (frameStart),
    .hit        (hit)
  );

  // Idle until the first frame start, so no byte counts before it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir <= tally_pkg::DIR_IDLE;
    end else begin
      dir <= next_dir;
    end
  end

  // Wraps at 12 bits; a frame that long meets the limit again but gives no second hit until next frame
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      running_byte_tally <= tally_pkg::TALLY_RST;
    end else begin
      running_byte_tally <= next_running_byte_tally;
    end
  end

  // Read data stands one cycle, then returns to zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= next_regRdData;
    end
  end
endmodule
`default_nettype wire

// >>> pkg/tally_pkg.sv
// Package for the frame byte tally and threshold block.
// Assumes an 8-bit register port with one-cycle-late read data.
package tally_pkg;
  localparam int unsigned TALLY_W          = 12;
  localparam int unsigned ADDR_W           = 3;
  // Register indices on the byte-wide port
  localparam logic [2:0]  COUNT_LOW_ADDR   = 3'h0;
  localparam logic [2:0]  COUNT_HIGH_ADDR  = 3'h1;
  localparam logic [2:0]  LIMIT_LOW_ADDR   = 3'h2;
  localparam logic [2:0]  LIMIT_HIGH_ADDR  = 3'h3;
  localparam logic [2:0]  EVENT_MASK_ADDR  = 3'h4;
  localparam logic [2:0]  EVENT_STAT_ADDR  = 3'h5;
  // Field positions
  localparam int unsigned HIGH_NIB_LSB     = 0;
  localparam int unsigned HIGH_NIB_W       = 4;
  localparam int unsigned TX_EVT_BIT       = 0;
  localparam int unsigned RX_EVT_BIT       = 1;
  // Reset values
  localparam logic [11:0] TALLY_RST        = 12'h000;
  localparam logic [11:0] LIMIT_RST        = 12'h000;
  localparam logic [1:0]  MASK_RST         = 2'h3;
  localparam logic [7:0]  UNMAPPED_RD      = 8'h00;

  typedef enum logic [1:0] {
    DIR_IDLE = 2'b00,
    DIR_TX   = 2'b01,
    DIR_RX   = 2'b10
  } dir_t;
endpackage

// >>> verilog/limit_compare.sv
// Limit comparator: flags the cycle the tally first equals the limit.
// Assumes tally and limit are registered in the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module limit_compare (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  input  wire logic [tally_pkg::TALLY_W-1:0] tally,
  input  wire logic [tally_pkg::TALLY_W-1:0] limit,
  input  wire logic                         frameStart,
  output logic                              hit
);
  logic equalNow;
  logic armed;
  logic next_armed;

  assign equalNow = (tally == limit);

  // One event per frame; re-armed at each frame start
  always_comb begin
    next_armed = armed;
    if (frameStart) begin
      next_armed = 1'b1;
    end else if (equalNow && armed) begin
      next_armed = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
    end else begin
      armed <= next_armed;
    end
  end

  assign hit = equalNow && armed && !frameStart;
endmodule
`default_nettype wire

// >>> dv/frame_byte_counter_limit_chk.sv
// Checker for the frame byte tally: event timing, direction and read-back.
// Assumes it is bound onto frame_byte_counter_limit, one clock domain.
`timescale 1ns/100ps
`default_nettype none
module frame_byte_counter_limit_chk (
  input wire logic                         ref_clk,
  input wire logic                         rst_n,
  input wire logic [tally_pkg::ADDR_W-1:0] regAddr,
  input wire logic                         regWrite,
  input wire logic                         regRead,
  input wire logic [7:0]                   regRdData,
  input wire logic                         txFrameStart,
  input wire logic                         txByteSent,
  input wire logic                         txAfterDelim,
  input wire logic                         txCrcByte,
  input wire logic                         rxFrameStart,
  input wire logic                         rxFifoWrite,
  input wire logic                         rxPreambleByte,
  input wire logic                         tx_threshold_event,
  input wire logic                         rx_threshold_event
);
  logic lastTx;
  logic txCause;
  logic rxCause;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // A limit write can also make the tally equal
  assign txCause = txFrameStart | regWrite | (txByteSent & txAfterDelim & ~txCrcByte);
  assign rxCause = rxFrameStart | regWrite | (rxFifoWrite & ~rxPreambleByte);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lastTx <= 1'b0;
    end else if (txFrameStart || rxFrameStart) begin
      lastTx <= txFrameStart;
    end
  end
  tx_pulse_a: assert property (tx_threshold_event |=> !tx_threshold_event) else $error("tx event too long");
  rx_pulse_a: assert property (rx_threshold_event |=> !rx_threshold_event) else $error("rx event too long");
  one_dir_a: assert property (!(tx_threshold_event && rx_threshold_event)) else $error("both events");
  tx_dir_a: assert property (tx_threshold_event |-> lastTx) else $error("tx event outside tx");
  rx_dir_a: assert property (rx_threshold_event |-> !lastTx) else $error("rx event outside rx");
  tx_cause_a: assert property (tx_threshold_event |-> $past(txCause, 2)) else $error("tx event uncaused");
  rx_cause_a: assert property (rx_threshold_event |-> $past(rxCause, 2)) else $error("rx event uncaused");
  rsv_zero_a: assert property (regRead && regAddr == 3'h1 |=> regRdData[7:4] == 4'h0) else $error("rsv bits");
endmodule
bind frame_byte_counter_limit frame_byte_counter_limit_chk i_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .txFrameStart(txFrameStart), .txByteSent(txByteSent), .txAfterDelim(txAfterDelim), .txCrcByte(txCrcByte),
  .rxFrameStart(rxFrameStart), .rxFifoWrite(rxFifoWrite), .rxPreambleByte(rxPreambleByte),
  .tx_threshold_event(tx_threshold_event), .rx_threshold_event(rx_threshold_event));
`default_nettype wire

// >>> dv/frame_source_model.sv
// Model of the transmit and receive paths feeding byte strobes.
// Assumes the caller waits for each frame task to return.
`timescale 1ns/100ps
`default_nettype none
module frame_source_model (
  input  wire logic ref_clk,
  output var logic  txFrameStart,
  output var logic  txByteSent,
  output var logic  txAfterDelim,
  output var logic  txCrcByte,
  output var logic  rxFrameStart,
  output var logic  rxFifoWrite,
  output var logic  rxPreambleByte
);
  initial begin
    {txFrameStart, txByteSent, txAfterDelim, txCrcByte} = 4'h0;
    {rxFrameStart, rxFifoWrite, rxPreambleByte} = 3'h0;
  end
  // Bytes go back to back, the hardest pace for the tally
  task automatic tx_frame(input int pre, input int n, input int crc);
    @(posedge ref_clk) txFrameStart <= 1'b1;
    for (int i = 0; i < pre + n + crc; i++) begin
      @(posedge ref_clk) txFrameStart <= 1'b0;
      txByteSent   <= 1'b1;
      txAfterDelim <= (i >= pre);
      txCrcByte    <= (i >= pre + n);
    end
    @(posedge ref_clk) txByteSent <= 1'b0;
    txAfterDelim <= 1'b0;
    txCrcByte    <= 1'b0;
  endtask
  task automatic rx_frame(input int pre, input int n);
    @(posedge ref_clk) rxFrameStart <= 1'b1;
    for (int i = 0; i < pre + n; i++) begin
      @(posedge ref_clk) rxFrameStart <= 1'b0;
      rxFifoWrite    <= 1'b1;
      rxPreambleByte <= (i < pre);
    end
    @(posedge ref_clk) rxFifoWrite <= 1'b0;
    rxPreambleByte <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> dv/frame_byte_counter_limit_tb_top.sv
// Testbench: register access, frames in both directions, masked events.
// Assumes the model drives the path strobes and the checker is bound.
`timescale 1ns/100ps
`default_nettype none
module frame_byte_counter_limit_tb_top;
  logic                         ref_clk;
  logic                         rst_n;
  logic [tally_pkg::ADDR_W-1:0] regAddr;
  logic [7:0]                   regWrData;
  logic                         regWrite;
  logic                         regRead;
  logic [7:0]                   regRdData;
  logic                         txFs, txBs, txAd, txCrc, rxFs, rxFw, rxPre, txEv, rxEv;
  int                           failures = 0;
  int                           compares = 0;
  int                           txEvents = 0;
  int                           rxEvents = 0;
  logic [7:0]                   rstVal [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00};
  frame_byte_counter_limit i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .txFrameStart(txFs), .txByteSent(txBs),
    .txAfterDelim(txAd), .txCrcByte(txCrc), .rxFrameStart(rxFs), .rxFifoWrite(rxFw), .rxPreambleByte(rxPre),
    .tx_threshold_event(txEv), .rx_threshold_event(rxEv));
  frame_source_model i_src (.ref_clk(ref_clk), .txFrameStart(txFs), .txByteSent(txBs), .txAfterDelim(txAd),
    .txCrcByte(txCrc), .rxFrameStart(rxFs), .rxFifoWrite(rxFw), .rxPreambleByte(rxPre));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Sampled mid-cycle, clear of the launching edge
  always @(negedge ref_clk) begin
    if (txEv === 1'b1) txEvents++;
    if (rxEv === 1'b1) rxEvents++;
  end
  task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk) regWrite <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge ref_clk) regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk) regRead <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk) regRead <= 1'b0;
    #1 check({4'h0, regRdData}, {4'h0, exp}, "read data");
    @(posedge ref_clk) #1 check({4'h0, regRdData}, 12'h000, "idle read data");
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    tally_and_finish;
  end
  initial begin
    {rst_n, regAddr, regWrData, regWrite, regRead} = '0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rd(3'(i), rstVal[i]);
    // Tally registers are never written by this bench
    wr(3'h2, 8'h05);
    wr(3'h3, 8'h01);
    wr(3'h4, 8'h00);
    rd(3'h2, 8'h05);
    rd(3'h3, 8'h01);
    i_src.tx_frame(3, 263, 4);
    repeat (4) @(posedge ref_clk);
    rd(3'h0, 8'h07);
    rd(3'h1, 8'h01);
    check(12'(txEvents), 12'h001, "tx events");
    check(12'(rxEvents), 12'h000, "rx events");
    rd(3'h5, 8'h01);
    wr(3'h5, 8'h01);
    rd(3'h5, 8'h00);
    wr(3'h2, 8'h03);
    wr(3'h3, 8'h00);
    i_src.rx_frame(2, 5);
    repeat (4) @(posedge ref_clk);
    rd(3'h0, 8'h05);
    check(12'(rxEvents), 12'h001, "rx events");
    check(12'(txEvents), 12'h001, "tx events");
    wr(3'h4, 8'h03);
    i_src.tx_frame(1, 3, 2);
    repeat (4) @(posedge ref_clk);
    rd(3'h0, 8'h03);
    rd(3'h5, 8'h03);
    check(12'(txEvents), 12'h001, "masked tx events");
    tally_and_finish;
  end
endmodule
`default_nettype wire
